// ===== rtl/acd_map.vh
`ifndef ACD_MAP_VH
`define ACD_MAP_VH
// Byte lanes of the fetch window; the oldest byte sits lowest.
`define ACD_B0        7:0
`define ACD_B1        15:8
`define ACD_B2        23:16
`define ACD_B3        31:24
`define ACD_B4        39:32
// Field positions inside an opcode or operand byte.
`define ACD_NIB_HI    7:4
`define ACD_NIB_LO    3:0
`define ACD_OPCLS     3:1
`define ACD_CARRY_BIT 0
`define ACD_DIR_BIT   7
`define ACD_SEL       6:4
`define ACD_PAIR      5:4
`define ACD_RZERO     3
`define ACD_RSRC      2:0
// Operation-byte class: low nibble 100x, x is the carry-in select.
`define ACD_OPCLS_ADD 3'h4
// Upper nibble of single-byte operation codes.
`define ACD_HI_ACC_IMM 4'ha
`define ACD_HI_REG_FRM 4'h7
`define ACD_HI_S2_IMM  4'h6
`define ACD_HI_REG_REG 4'h8
`define ACD_HI_ACC_S2  4'h9
// Prefix bytes.
`define ACD_PFX_SHORT1 8'h3c
`define ACD_PFX_SFR    8'h01
`define ACD_PFX_MEMMEM 8'h2a
`define ACD_PFX_INDIR  8'h07
`define ACD_PFX_WIDE   8'h0a
`define ACD_PFX_BASE   8'h06
`define ACD_PFX_PTR    8'h16
`define ACD_PFX_BIDX   8'h17
// Register-form selector in the second byte low nibble.
`define ACD_RF_R_S2   4'h0
`define ACD_RF_R_S1   4'h1
`define ACD_RF_R_SFR  4'h2
`define ACD_RF_R_IMM  4'h3
`define ACD_RF_S2_R   4'h4
`define ACD_RF_S1_R   4'h5
`define ACD_RF_SFR_R  4'h6
// Selectors under the indirect, wide, base and pointer prefixes.
`define ACD_IND_WORD  3'h2
`define ACD_IND_LONG  3'h3
`define ACD_WIDE_ABS16 3'h4
`define ACD_WIDE_ABS24 3'h5
`define ACD_BASE_LAST  3'h4
`define ACD_PTR_PLAIN  3'h6
// Addressing modes reported to execute.
`define ACD_M_NONE     5'h00
`define ACD_M_ACC_IMM  5'h01
`define ACD_M_REG_IMM  5'h02
`define ACD_M_REG_S2   5'h03
`define ACD_M_REG_S1   5'h04
`define ACD_M_S2_REG   5'h05
`define ACD_M_S1_REG   5'h06
`define ACD_M_REG_SFR  5'h07
`define ACD_M_SFR_REG  5'h08
`define ACD_M_S2_IMM   5'h09
`define ACD_M_S1_IMM   5'h0a
`define ACD_M_SFR_IMM  5'h0b
`define ACD_M_REG_REG1 5'h0c
`define ACD_M_REG_REG2 5'h0d
`define ACD_M_ACC_S2   5'h0e
`define ACD_M_MEM_MEM  5'h0f
`define ACD_M_PTR_WORD 5'h10
`define ACD_M_PTR_LONG 5'h11
`define ACD_M_ABS16    5'h12
`define ACD_M_ABS24    5'h13
`define ACD_M_PTR_AUTO 5'h14
`define ACD_M_BASE_OFS 5'h15
`define ACD_M_IMM_IDX  5'h16
`define ACD_M_BASE_IDX 5'h17
// Pointer, index and step selectors.
`define ACD_PTR_TRI1  3'h0
`define ACD_PTR_TRI2  3'h1
`define ACD_PTR_TRI3  3'h2
`define ACD_PTR_TRI4  3'h3
`define ACD_PTR_SP    3'h4
`define ACD_PTR_NONE  3'h7
`define ACD_IDX_DE    3'h0
`define ACD_IDX_A     3'h1
`define ACD_IDX_HL    3'h2
`define ACD_IDX_B     3'h3
`define ACD_IDX_C     3'h4
`define ACD_IDX_NONE  3'h7
`define ACD_STEP_NONE 2'h0
`define ACD_STEP_INC  2'h1
`define ACD_STEP_DEC  2'h2
// Instruction lengths in bytes.
`define ACD_LEN1 3'h1
`define ACD_LEN2 3'h2
`define ACD_LEN3 3'h3
`define ACD_LEN4 3'h4
`define ACD_LEN5 3'h5
// Address byte orders.
`define ACD_ORD_BYTE 2'h0
`define ACD_ORD_LH   2'h1
`define ACD_ORD_LHW  2'h2
`define ACD_ORD_WLH  2'h3
`endif

// ===== rtl/acd_opsel.v
`timescale 1ns/100ps
`include "acd_map.vh"
module acd_opsel (
  // Candidate operation byte
  input  wire [7:0] i_byte,
  // Classification
  output wire       o_ok,
  output wire       o_carry
);
  // Add and add-with-carry share every field but the lowest opcode bit.
  assign o_ok    = (i_byte[`ACD_OPCLS] == `ACD_OPCLS_ADD); // RULE_21
  assign o_carry = i_byte[`ACD_CARRY_BIT]; // RULE_21
endmodule

// ===== rtl/acd_addr_pack.v
`timescale 1ns/100ps
`include "acd_map.vh"
module acd_addr_pack (
  // Operand bytes
  input  wire [7:0]  i_ofs,
  input  wire [7:0]  i_b2,
  input  wire [7:0]  i_b3,
  input  wire [7:0]  i_b4,
  input  wire [1:0]  i_ord,
  // Assembled address
  output reg  [23:0] o_addr
);
  always @* begin
    case (i_ord)
      `ACD_ORD_LH:  o_addr = {8'h00, i_b3, i_b2}; // RULE_14
      `ACD_ORD_LHW: o_addr = {i_b4, i_b3, i_b2}; // RULE_19
      `ACD_ORD_WLH: o_addr = {i_b2, i_b4, i_b3}; // RULE_15
      default:      o_addr = {16'h0000, i_ofs};
    endcase
  end
endmodule

// ===== rtl/acd_decoder.v
// Operation
// RULE_01: A9 is accumulator immediate, two bytes.
// RULE_02: 79 with nibble 3 is register immediate.
// RULE_03: 79 low nibble picks register/short/sfr form.
// RULE_04: 69 adds immediate into region-two location.
// RULE_05: 3C 69 adds immediate into region one.
// RULE_06: 01 69 adds immediate into sfr.
// RULE_07: 89 is register add, low-group source.
// RULE_08: 3C 89 uses alternate source group.
// RULE_09: 99 adds region-two location into accumulator.
// RULE_10: 2A prefix gives memory-to-memory forms.
// RULE_11: 07 prefix gives word-pointer load/store.
// RULE_12: 3C before 07 moves pointer to region one.
// RULE_13: 07 with x3/xB9 uses 24-bit pointer.
// RULE_14: 0A 49/C9 uses 16-bit absolute address.
// RULE_15: 0A 59/D9 uses 24-bit absolute address.
// RULE_16: 16 prefix gives pointer auto-step modes.
// RULE_17: Second-byte bit 7 selects memory destination.
// RULE_18: 06 prefix gives base plus byte offset.
// RULE_19: 0A low selectors give indexed wide base.
// RULE_20: 17 prefix gives based-indexed modes.
// RULE_21: Low nibble 8 is add, 9 with carry.
// RULE_22: Report operation, mode, fields and length.
`timescale 1ns/100ps
`include "acd_map.vh"
module acd_decoder (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Fetch window
  input  wire        i_valid,
  input  wire [2:0]  i_avail,
  input  wire [39:0] i_window,
  // Decoded instruction
  output reg         o_valid,
  output reg         o_known,
  output reg         o_starve,
  output reg         o_carry,
  output reg  [4:0]  o_mode,
  output reg  [2:0]  o_len,
  output reg         o_store,
  output reg  [3:0]  o_reg_dst,
  output reg  [2:0]  o_reg_src,
  output reg         o_src_alt,
  output reg  [2:0]  o_ptr,
  output reg  [2:0]  o_idx,
  output reg  [1:0]  o_step,
  output reg  [1:0]  o_region,
  output reg  [23:0] o_addr,
  output reg  [7:0]  o_addr2,
  output reg  [7:0]  o_imm
);

  wire [7:0]  b0;
  wire [7:0]  b1;
  wire [7:0]  b2;
  wire [7:0]  b3;
  wire [7:0]  b4;
  wire [2:0]  op_ok;
  wire [2:0]  op_c;
  wire [23:0] addr_w;
  wire        ind_pfx1;
  wire [7:0]  ind_op;
  wire [7:0]  ind_ofs;

  reg         known_d;
  reg         carry_d;
  reg  [4:0]  mode_d;
  reg  [2:0]  len_d;
  reg         store_d;
  reg  [3:0]  rdst_d;
  reg  [2:0]  rsrc_d;
  reg         alt_d;
  reg  [2:0]  ptr_d;
  reg  [2:0]  idx_d;
  reg  [1:0]  step_d;
  reg  [1:0]  region_d;
  reg  [1:0]  ord_d;
  reg  [7:0]  ofs_d;
  reg  [7:0]  addr2_d;
  reg  [7:0]  imm_d;
  reg         ind_go;
  reg  [2:0]  sel;
  wire        fits;

  assign b0 = i_window[`ACD_B0];
  assign b1 = i_window[`ACD_B1];
  assign b2 = i_window[`ACD_B2];
  assign b3 = i_window[`ACD_B3];
  assign b4 = i_window[`ACD_B4];

  // Every one of the first three bytes can be the operation byte.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_op
      acd_opsel u_opsel (
        .i_byte  (i_window[gi*8 +: 8]),
        .o_ok    (op_ok[gi]),
        .o_carry (op_c[gi])
      );
    end
  endgenerate

  // The region-one prefix pushes the indirect group one byte later.
  assign ind_pfx1 = (b0 == `ACD_PFX_SHORT1); // RULE_12
  assign ind_op   = ind_pfx1 ? b2 : b1;
  assign ind_ofs  = ind_pfx1 ? b3 : b2;

  acd_addr_pack u_pack (
    .i_ofs  (ofs_d),
    .i_b2   (b2),
    .i_b3   (b3),
    .i_b4   (b4),
    .i_ord  (ord_d),
    .o_addr (addr_w)
  );

  always @* begin
    known_d  = 1'b0;
    carry_d  = op_c[0];
    mode_d   = `ACD_M_NONE;
    len_d    = `ACD_LEN1;
    store_d  = 1'b0;
    rdst_d   = 4'h0;
    rsrc_d   = 3'h0;
    alt_d    = 1'b0;
    ptr_d    = `ACD_PTR_NONE;
    idx_d    = `ACD_IDX_NONE;
    step_d   = `ACD_STEP_NONE;
    region_d = 2'h0;
    ord_d    = `ACD_ORD_BYTE;
    ofs_d    = b1;
    addr2_d  = 8'h00;
    imm_d    = 8'h00;
    ind_go   = 1'b0;
    sel      = b1[`ACD_SEL];
    if (op_ok[0]) begin
      case (b0[`ACD_NIB_HI])
        `ACD_HI_ACC_IMM: begin
          known_d = 1'b1; // RULE_01
          mode_d  = `ACD_M_ACC_IMM;
          len_d   = `ACD_LEN2;
          imm_d   = b1;
        end
        `ACD_HI_REG_FRM: begin
          known_d = 1'b1;
          rdst_d  = b1[`ACD_NIB_HI]; // RULE_02
          ofs_d   = b2; // RULE_03
          len_d   = `ACD_LEN3;
          case (b1[`ACD_NIB_LO])
            `ACD_RF_R_IMM: begin
              mode_d = `ACD_M_REG_IMM; // RULE_02
              imm_d  = b2;
              ofs_d  = 8'h00;
            end
            `ACD_RF_R_S2:  mode_d = `ACD_M_REG_S2; // RULE_03
            `ACD_RF_R_S1: begin
              mode_d   = `ACD_M_REG_S1; // RULE_03
              region_d = 2'h3;
            end
            `ACD_RF_S2_R: begin
              mode_d  = `ACD_M_S2_REG; // RULE_03
              store_d = 1'b1;
            end
            `ACD_RF_S1_R: begin
              mode_d   = `ACD_M_S1_REG; // RULE_03
              store_d  = 1'b1;
              region_d = 2'h3;
            end
            `ACD_RF_R_SFR: mode_d = `ACD_M_REG_SFR; // RULE_03
            `ACD_RF_SFR_R: begin
              mode_d  = `ACD_M_SFR_REG; // RULE_03
              store_d = 1'b1;
            end
            default: known_d = 1'b0;
          endcase
        end
        `ACD_HI_S2_IMM: begin
          known_d = 1'b1; // RULE_04
          mode_d  = `ACD_M_S2_IMM;
          len_d   = `ACD_LEN3;
          imm_d   = b2;
        end
        `ACD_HI_REG_REG: begin
          known_d = ~b1[`ACD_RZERO]; // RULE_07
          mode_d  = `ACD_M_REG_REG1;
          len_d   = `ACD_LEN2;
          rdst_d  = b1[`ACD_NIB_HI];
          rsrc_d  = b1[`ACD_RSRC];
          ofs_d   = 8'h00;
        end
        `ACD_HI_ACC_S2: begin
          known_d = 1'b1; // RULE_09
          mode_d  = `ACD_M_ACC_S2;
          len_d   = `ACD_LEN2;
        end
        default: known_d = 1'b0;
      endcase
    end else begin
      case (b0)
        `ACD_PFX_SHORT1: begin
          carry_d = op_c[1];
          if (b1 == `ACD_PFX_INDIR) begin
            ind_go = 1'b1; // RULE_12
          end else if (op_ok[1] && b1[`ACD_NIB_HI] == `ACD_HI_S2_IMM) begin
            known_d  = 1'b1; // RULE_05
            mode_d   = `ACD_M_S1_IMM;
            len_d    = `ACD_LEN4;
            ofs_d    = b2;
            imm_d    = b3;
            region_d = 2'h3;
          end else if (op_ok[1] && b1[`ACD_NIB_HI] == `ACD_HI_REG_REG) begin
            known_d = ~b2[`ACD_RZERO]; // RULE_08
            mode_d  = `ACD_M_REG_REG2;
            len_d   = `ACD_LEN3;
            rdst_d  = b2[`ACD_NIB_HI];
            rsrc_d  = b2[`ACD_RSRC];
            alt_d   = 1'b1;
            ofs_d   = 8'h00;
          end
        end
        `ACD_PFX_SFR: begin
          carry_d = op_c[1];
          known_d = op_ok[1] && b1[`ACD_NIB_HI] == `ACD_HI_S2_IMM; // RULE_06
          mode_d  = `ACD_M_SFR_IMM;
          len_d   = `ACD_LEN4;
          ofs_d   = b2;
          imm_d   = b3;
        end
        `ACD_PFX_MEMMEM: begin
          carry_d  = op_c[1];
          known_d  = op_ok[1] && !b1[`ACD_DIR_BIT] && !b1[6]; // RULE_10
          mode_d   = `ACD_M_MEM_MEM;
          len_d    = `ACD_LEN4;
          region_d = b1[`ACD_PAIR];
          ofs_d    = b2;
          addr2_d  = b3;
        end
        `ACD_PFX_INDIR: ind_go = 1'b1; // RULE_11
        `ACD_PFX_WIDE: begin
          carry_d = op_c[1];
          store_d = b1[`ACD_DIR_BIT]; // RULE_17
          known_d = op_ok[1] && sel <= `ACD_WIDE_ABS24;
          if (sel == `ACD_WIDE_ABS16) begin
            mode_d = `ACD_M_ABS16; // RULE_14
            len_d  = `ACD_LEN4;
            ord_d  = `ACD_ORD_LH;
          end else if (sel == `ACD_WIDE_ABS24) begin
            mode_d = `ACD_M_ABS24; // RULE_15
            len_d  = `ACD_LEN5;
            ord_d  = `ACD_ORD_WLH;
          end else begin
            mode_d = `ACD_M_IMM_IDX; // RULE_19
            len_d  = `ACD_LEN5;
            ord_d  = `ACD_ORD_LHW;
            case (sel[1:0])
              2'h0:    idx_d = `ACD_IDX_DE;
              2'h1:    idx_d = `ACD_IDX_A;
              2'h2:    idx_d = `ACD_IDX_HL;
              default: idx_d = `ACD_IDX_B;
            endcase
          end
        end
        `ACD_PFX_BASE: begin
          carry_d = op_c[1];
          store_d = b1[`ACD_DIR_BIT]; // RULE_17
          known_d = op_ok[1] && sel <= `ACD_BASE_LAST; // RULE_18
          mode_d  = `ACD_M_BASE_OFS;
          len_d   = `ACD_LEN3;
          ofs_d   = b2;
          case (sel)
            3'h0:    ptr_d = `ACD_PTR_TRI1;
            3'h1:    ptr_d = `ACD_PTR_SP;
            3'h2:    ptr_d = `ACD_PTR_TRI2;
            3'h3:    ptr_d = `ACD_PTR_TRI4;
            default: ptr_d = `ACD_PTR_TRI3;
          endcase
        end
        `ACD_PFX_PTR: begin
          carry_d = op_c[1];
          store_d = b1[`ACD_DIR_BIT]; // RULE_17
          known_d = op_ok[1]; // RULE_16
          mode_d  = `ACD_M_PTR_AUTO;
          len_d   = `ACD_LEN2;
          ofs_d   = 8'h00;
          if (sel < `ACD_PTR_PLAIN)
            ptr_d = sel[0] ? `ACD_PTR_TRI2 : `ACD_PTR_TRI1;
          else
            ptr_d = sel[0] ? `ACD_PTR_TRI4 : `ACD_PTR_TRI3;
          if (sel[2])
            step_d = `ACD_STEP_NONE;
          else if (sel[1])
            step_d = `ACD_STEP_DEC;
          else
            step_d = `ACD_STEP_INC;
        end
        `ACD_PFX_BIDX: begin
          carry_d = op_c[1];
          store_d = b1[`ACD_DIR_BIT]; // RULE_17
          known_d = op_ok[1]; // RULE_20
          mode_d  = `ACD_M_BASE_IDX;
          len_d   = `ACD_LEN2;
          ofs_d   = 8'h00;
          case (sel)
            3'h0: begin
              ptr_d = `ACD_PTR_TRI1;
              idx_d = `ACD_IDX_A;
            end
            3'h1: begin
              ptr_d = `ACD_PTR_TRI2;
              idx_d = `ACD_IDX_A;
            end
            3'h2: begin
              ptr_d = `ACD_PTR_TRI1;
              idx_d = `ACD_IDX_B;
            end
            3'h3: begin
              ptr_d = `ACD_PTR_TRI2;
              idx_d = `ACD_IDX_B;
            end
            3'h4: begin
              ptr_d = `ACD_PTR_TRI3;
              idx_d = `ACD_IDX_DE;
            end
            3'h5: begin
              ptr_d = `ACD_PTR_TRI3;
              idx_d = `ACD_IDX_HL;
            end
            3'h6: begin
              ptr_d = `ACD_PTR_TRI1;
              idx_d = `ACD_IDX_C;
            end
            default: begin
              ptr_d = `ACD_PTR_TRI2;
              idx_d = `ACD_IDX_C;
            end
          endcase
        end
        default: known_d = 1'b0;
      endcase
    end
    // Both entries into the indirect group share one operand layout.
    if (ind_go) begin
      sel      = ind_op[`ACD_SEL];
      carry_d  = ind_pfx1 ? op_c[2] : op_c[1];
      known_d  = (ind_pfx1 ? op_ok[2] : op_ok[1]) &&
                 (sel == `ACD_IND_WORD || sel == `ACD_IND_LONG);
      store_d  = ind_op[`ACD_DIR_BIT]; // RULE_11
      mode_d   = (sel == `ACD_IND_LONG) ? `ACD_M_PTR_LONG // RULE_13
                                        : `ACD_M_PTR_WORD;
      ofs_d    = ind_ofs;
      len_d    = ind_pfx1 ? `ACD_LEN4 : `ACD_LEN3; // RULE_12
      region_d = ind_pfx1 ? 2'h3 : 2'h0;
    end
    if (!known_d) begin
      mode_d = `ACD_M_NONE;
      len_d  = `ACD_LEN1;
    end
  end

  // An instruction is only reported once all of its bytes are present, so
  // fetch never advances past a half-seen encoding.
  assign fits = (i_avail >= len_d);

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_valid   <= 1'b0;
      o_known   <= 1'b0;
      o_starve  <= 1'b0;
      o_carry   <= 1'b0;
      o_mode    <= `ACD_M_NONE;
      o_len     <= `ACD_LEN1;
      o_store   <= 1'b0;
      o_reg_dst <= 4'h0;
      o_reg_src <= 3'h0;
      o_src_alt <= 1'b0;
      o_ptr     <= `ACD_PTR_NONE;
      o_idx     <= `ACD_IDX_NONE;
      o_step    <= `ACD_STEP_NONE;
      o_region  <= 2'h0;
      o_addr    <= 24'h000000;
      o_addr2   <= 8'h00;
      o_imm     <= 8'h00;
    end else begin
      o_valid  <= i_valid && fits; // RULE_22
      o_starve <= i_valid && !fits;
      if (i_valid && fits) begin
        o_known   <= known_d; // RULE_22
        o_carry   <= carry_d;
        o_mode    <= mode_d;
        o_len     <= len_d;
        o_store   <= store_d;
        o_reg_dst <= rdst_d;
        o_reg_src <= rsrc_d;
        o_src_alt <= alt_d;
        o_ptr     <= ptr_d;
        o_idx     <= idx_d;
        o_step    <= step_d;
        o_region  <= region_d;
        o_addr    <= addr_w;
        o_addr2   <= addr2_d;
        o_imm     <= imm_d;
      end
    end
  end

endmodule

// ===== test/acd_fetch_model.sv
`timescale 1ns/100ps
// Fetch queue stand-in: each send presents one window for one cycle, then goes idle.
module acd_fetch_model (
  // Clock
  input  wire        i_clk,
  // Window towards the decoder
  output reg         o_valid,
  output reg  [2:0]  o_avail,
  output reg  [39:0] o_window
);
  initial begin
    o_valid  = 1'b0;
    o_avail  = 3'h0;
    o_window = 40'h0;
  end
  // Idle bytes are inverted so a stale window can never pass for a live one.
  task idle;
    begin
      o_valid  = 1'b0;
      o_avail  = 3'h0;
      o_window = ~o_window;
    end
  endtask
  task put(input [39:0] w, input [2:0] av);
    begin
      o_valid  = 1'b1;
      o_avail  = av;
      o_window = w;
    end
  endtask
  task send(input [39:0] w, input [2:0] av);
    begin
      @(posedge i_clk);
      #1 put(w, av);
      @(posedge i_clk);
      #1 idle;
    end
  endtask
endmodule

// ===== test/acd_decoder_props.sv
`timescale 1ns/100ps
module acd_chk (
  // Clock and reset
  input wire        i_clk,
  input wire        i_rst_n,
  // Fetch window
  input wire        i_valid,
  input wire [2:0]  i_avail,
  input wire [39:0] i_window,
  // Decoded instruction
  input wire        o_valid,
  input wire        o_known,
  input wire        o_starve,
  input wire        o_carry,
  input wire [4:0]  o_mode,
  input wire [2:0]  o_len,
  input wire [3:0]  o_reg_dst,
  input wire [2:0]  o_reg_src,
  input wire        o_src_alt,
  input wire [1:0]  o_region,
  input wire [23:0] o_addr,
  input wire [7:0]  o_imm
);
  reg [39:0] win_q;
  always @(posedge i_clk) win_q <= i_window;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_answer_once: assert property (i_valid |=> o_valid != o_starve)
    else $error("decode gave no single answer");
  a_idle_quiet: assert property (!i_valid |=> !o_valid && !o_starve)
    else $error("answer without a request");
  a_acc_imm: assert property (i_valid && i_avail >= 3'h2 &&
    i_window[7:0] == 8'ha9 |=> o_valid && o_known && o_carry &&
    o_mode == 5'h01 && o_len == 3'h2 && o_imm == win_q[15:8])
    else $error("accumulator immediate wrong");
  a_plain_add: assert property (i_valid && i_avail >= 3'h2 &&
    i_window[7:0] == 8'ha8 |=> o_valid && !o_carry && o_mode == 5'h01)
    else $error("plain add flagged as carry");
  a_reg_imm: assert property (i_valid && i_avail >= 3'h3 &&
    i_window[7:0] == 8'h79 && i_window[11:8] == 4'h3 |=>
    o_mode == 5'h02 && o_len == 3'h3 && o_reg_dst == win_q[15:12] &&
    o_imm == win_q[23:16]) else $error("register immediate wrong");
  a_short1_imm: assert property (i_valid && i_avail >= 3'h4 &&
    i_window[15:0] == 16'h693c |=> o_mode == 5'h0a && o_len == 3'h4 &&
    o_region == 2'h3 && o_addr == {16'h0, win_q[23:16]} &&
    o_imm == win_q[31:24]) else $error("region one immediate wrong");
  a_reg_reg: assert property (i_valid && i_avail >= 3'h2 &&
    i_window[7:0] == 8'h89 && !i_window[11] |=> o_mode == 5'h0c &&
    o_len == 3'h2 && o_reg_src == win_q[10:8] && !o_src_alt)
    else $error("register pair add wrong");
  a_abs_long: assert property (i_valid && i_avail == 3'h5 &&
    i_window[7:0] == 8'h0a && i_window[14:8] == 7'h59 |=>
    o_mode == 5'h13 && o_len == 3'h5 &&
    o_addr == {win_q[23:16], win_q[39:32], win_q[31:24]})
    else $error("long absolute byte order wrong");
  a_starve_keep: assert property (i_valid && i_avail == 3'h0 |=>
    o_starve && !o_valid && $stable(o_mode) && $stable(o_addr))
    else $error("short window changed fields");
endmodule
bind acd_decoder acd_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_valid(i_valid), .i_avail(i_avail), .i_window(i_window),
  .o_valid(o_valid), .o_known(o_known), .o_starve(o_starve),
  .o_carry(o_carry), .o_mode(o_mode), .o_len(o_len),
  .o_reg_dst(o_reg_dst), .o_reg_src(o_reg_src), .o_src_alt(o_src_alt),
  .o_region(o_region), .o_addr(o_addr), .o_imm(o_imm));

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
  reg         i_clk;
  reg         i_rst_n;
  wire        i_valid, o_valid, o_known, o_starve, o_carry, o_store;
  wire        o_src_alt;
  wire [2:0]  i_avail, o_len, o_reg_src, o_ptr, o_idx;
  wire [39:0] i_window;
  wire [4:0]  o_mode;
  wire [3:0]  o_reg_dst;
  wire [1:0]  o_step, o_region;
  wire [23:0] o_addr;
  wire [7:0]  o_addr2, o_imm;
  integer     num_errors, compares, k;
  localparam [14:0] BASE_PTR = 15'b010_011_001_100_000;
  localparam [23:0] BI_PTR = 24'o10221010;
  localparam [23:0] BI_IDX = 24'o44203311;
  localparam [23:0] RF_NIB = 24'h625410;
  acd_fetch_model fm (.i_clk(i_clk), .o_valid(i_valid), .o_avail(i_avail),
    .o_window(i_window));
  acd_decoder uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
    .i_avail(i_avail), .i_window(i_window), .o_valid(o_valid),
    .o_known(o_known), .o_starve(o_starve), .o_carry(o_carry),
    .o_mode(o_mode), .o_len(o_len), .o_store(o_store),
    .o_reg_dst(o_reg_dst), .o_reg_src(o_reg_src), .o_src_alt(o_src_alt),
    .o_ptr(o_ptr), .o_idx(o_idx), .o_step(o_step), .o_region(o_region),
    .o_addr(o_addr), .o_addr2(o_addr2), .o_imm(o_imm));
  initial i_clk = 1'b0;
  always #20 i_clk = ~i_clk;
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [23:0] got, input [23:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task ex(input [4:0] m, input [2:0] l, input c, input s);
    chk({o_valid, o_known, o_carry, o_store, 12'h0, o_mode, o_len},
      {2'b11, c, s, 12'h0, m, l});
  endtask
  task fp(input [2:0] p, input [2:0] x, input [1:0] st);
    chk({16'h0, o_ptr, o_idx, o_step}, {16'h0, p, x, st});
  endtask
  task fg(input [1:0] rg);
    chk({22'h0, o_region}, {22'h0, rg});
  endtask
  task fr(input [3:0] d, input [2:0] s, input a);
    chk({16'h0, o_reg_dst, o_reg_src, o_src_alt}, {16'h0, d, s, a});
  endtask
  task fi(input [7:0] imm);
    chk({16'h0, o_imm}, {16'h0, imm});
  endtask
  // An unknown encoding must still answer, with length one.
  task fu;
    chk({19'h0, o_valid, o_known, o_len}, {19'h0, 2'b10, 3'h1});
  endtask
  task t_imm;
    begin
      chk({2'h0, o_valid, o_starve, o_known, o_len, o_ptr, o_idx, o_mode},
        {2'h0, 3'h0, 3'h1, 3'h7, 3'h7, 5'h0});
      fm.send(40'h55a9, 3'h2);
      ex(5'h01, 3'h2, 1'b1, 1'b0);
      fi(8'h55);
      fm.send(40'h55a8, 3'h2);
      ex(5'h01, 3'h2, 1'b0, 1'b0);
      fm.send(40'h665379, 3'h3);
      ex(5'h02, 3'h3, 1'b1, 1'b0);
      fr(4'h5, 3'h0, 1'b0);
      fi(8'h66);
      $display("immediate test done");
    end
  endtask
  task t_regform;
    reg [3:0] nb;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        nb = RF_NIB[k*4+:4];
        fm.send({16'h0, 8'h40 + k[7:0], 4'hc, nb, 8'h79}, 3'h3);
        ex(5'h03 + k[4:0], 3'h3, 1'b1, nb[2]);
        fr(4'hc, 3'h0, 1'b0);
        chk(o_addr, 24'h40 + k[23:0]);
        if (k < 4) fg({2{nb[0]}});
      end
      $display("register form test done");
    end
  endtask
  task t_short;
    begin
      fm.send(40'h771269, 3'h3);
      ex(5'h09, 3'h3, 1'b1, 1'b0);
      chk(o_addr, 24'h12);
      fi(8'h77);
      fg(2'h0);
      fm.send(40'h8834693c, 3'h4);
      ex(5'h0a, 3'h4, 1'b1, 1'b0);
      fg(2'h3);
      fm.send(40'h99566901, 3'h4);
      ex(5'h0b, 3'h4, 1'b1, 1'b0);
      chk(o_addr, 24'h56);
      fi(8'h99);
      $display("short immediate test done");
    end
  endtask
  task t_regreg;
    begin
      fm.send(40'h5289, 3'h2);
      ex(5'h0c, 3'h2, 1'b1, 1'b0);
      fr(4'h5, 3'h2, 1'b0);
      fm.send(40'h61893c, 3'h3);
      ex(5'h0d, 3'h3, 1'b1, 1'b0);
      fr(4'h6, 3'h1, 1'b1);
      fm.send(40'h5a89, 3'h2);
      fu;
      fm.send(40'hab99, 3'h2);
      ex(5'h0e, 3'h2, 1'b1, 1'b0);
      chk(o_addr, 24'hab);
      $display("register pair test done");
    end
  endtask
  task t_mem;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        fm.send({16'hd030, 2'b0, k[1:0], 4'h9, 8'h2a}, 3'h4);
        ex(5'h0f, 3'h4, 1'b1, 1'b0);
        chk(o_addr, 24'h30);
        chk({16'h0, o_addr2}, 24'hd0);
        fg(k[1:0]);
      end
      for (k = 0; k < 4; k = k + 1) begin
        fm.send({16'h44, k[1], 2'b01, k[0], 4'h9, 8'h07}, 3'h3);
        ex(k[0] ? 5'h11 : 5'h10, 3'h3, 1'b1, k[1]);
        chk(o_addr, 24'h44);
      end
      fm.send(40'h20a9073c, 3'h4);
      ex(5'h10, 3'h4, 1'b1, 1'b1);
      fg(2'h3);
      $display("memory and indirect test done");
    end
  endtask
  task t_abs;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        fm.send({8'h0, 8'h12, 8'h34, k[0], 7'h49, 8'h0a}, 3'h4);
        ex(5'h12, 3'h4, 1'b1, k[0]);
        chk(o_addr, 24'h001234);
        fm.send({8'h56, 8'h78, 8'h9a, k[0], 7'h59, 8'h0a}, 3'h5);
        ex(5'h13, 3'h5, 1'b1, k[0]);
        chk(o_addr, 24'h9a5678);
      end
      for (k = 0; k < 8; k = k + 1) begin
        fm.send({24'hc3b2a1, k[2], 1'b0, k[1:0], 4'h9, 8'h0a}, 3'h5);
        ex(5'h16, 3'h5, 1'b1, k[2]);
        chk(o_addr, 24'hc3b2a1);
        fp(3'h7, {1'b0, k[1:0]}, 2'h0);
      end
      $display("absolute and wide base test done");
    end
  endtask
  task t_ptr;
    reg [2:0] bs;
    begin
      for (k = 0; k < 32; k = k + 1) begin
        fm.send({24'h0, k[3], k[2:0], 3'b100, k[4], 8'h16}, 3'h2);
        ex(5'h14, 3'h2, k[4], k[3]);
        fp(k[2:1] == 2'h3 ? k[2:0] - 3'h4 : {2'h0, k[0]}, 3'h7,
          k[2] ? 2'h0 : (k[1] ? 2'h2 : 2'h1));
        fm.send({24'h0, k[3], k[2:0], 3'b100, k[4], 8'h17}, 3'h2);
        ex(5'h17, 3'h2, k[4], k[3]);
        fp(BI_PTR[k[2:0]*3+:3], BI_IDX[k[2:0]*3+:3], 2'h0);
      end
      for (k = 0; k < 10; k = k + 1) begin
        // The selector runs 0 to 4 twice, loads first and then stores.
        bs = k[2:0] - ((k >= 5) ? 3'h5 : 3'h0);
        fm.send({16'h0, 8'h70 + k[7:0], k >= 5, bs, 4'h9, 8'h06}, 3'h3);
        ex(5'h15, 3'h3, 1'b1, k >= 5);
        chk(o_addr, 24'h70 + k[23:0]);
        fp(BASE_PTR[bs*3+:3], 3'h7, 2'h0);
      end
      fm.send(40'h705906, 3'h3);
      fu;
      $display("pointer modes test done");
    end
  endtask
  task t_starve;
    begin
      fm.send(40'h55a9, 3'h2);
      fm.send(40'h771269, 3'h2);
      chk({22'h0, o_valid, o_starve}, 24'h1);
      chk({13'h0, o_known, o_carry, o_store, o_mode, o_len},
        {13'h0, 3'b110, 5'h01, 3'h2});
      @(posedge i_clk);
      #1 fm.put(40'h5289, 3'h0);
      @(posedge i_clk);
      #1 fm.put(40'h61893c, 3'h3);
      chk({22'h0, o_valid, o_starve}, 24'h1);
      @(posedge i_clk);
      #1 fm.put(40'h8834693c, 3'h4);
      ex(5'h0d, 3'h3, 1'b1, 1'b0);
      @(posedge i_clk);
      #1 fm.idle;
      ex(5'h0a, 3'h4, 1'b1, 1'b0);
      chk(o_addr, 24'h34);
      $display("short window test done");
    end
  endtask
  initial begin
    num_errors = 0;
    compares = 0;
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    t_imm;
    t_regform;
    t_short;
    t_regreg;
    t_mem;
    t_abs;
    t_ptr;
    t_starve;
    close_out;
  end
  // The whole run takes about 240 cycles; this limit is far beyond that.
  initial begin
    #100000;
    num_errors = num_errors + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out;
  end
endmodule
